// ===== design/srec_pkg.sv
package srec_pkg;

    // Bus and code widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int VCODE_W = 11;
    localparam int ICODE_W = 8;
    localparam int VT_HI_W = 3;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h05;
    localparam logic [7:0] ADDR_CFG      = 8'h09;
    localparam logic [7:0] ADDR_VT_LO    = 8'h0a;
    localparam logic [7:0] ADDR_VT_HI    = 8'h0b;
    localparam logic [7:0] ADDR_IT       = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h0d;
    localparam logic [7:0] ADDR_VCODE_LO = 8'h0e;
    localparam logic [7:0] ADDR_VCODE_HI = 8'h0f;
    localparam logic [7:0] ADDR_ICODE    = 8'h10;

    // Field positions
    localparam int CTRL_SWEN_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CFG_DIS_BIT   = 4;
    localparam int CFG_DIV_LSB   = 6;
    localparam int STAT_IEN_BIT  = 0;
    localparam int STAT_VBSY_BIT = 1;
    localparam int STAT_IBSY_BIT = 2;
    localparam int STAT_PIN_BIT  = 3;
    localparam int STAT_BIAS_BIT = 4;

    // Voltage code ceiling
    localparam logic [10:0] VCODE_MAX = 11'h780;

    // Servo divider, count limit is ratio minus one
    localparam int         DIV_CNT_W = 8;
    localparam logic [7:0] DIV_LIM0  = 8'h00;
    localparam logic [7:0] DIV_LIM1  = 8'h03;
    localparam logic [7:0] DIV_LIM2  = 8'h0f;
    localparam logic [7:0] DIV_LIM3  = 8'h3f;

    // Reset values
    localparam logic       SWEN_RST  = 1'b0;
    localparam logic       DIS_RST   = 1'b0;
    localparam logic [1:0] DIV_RST   = 2'h0;
    localparam logic [7:0] VT_LO_RST = 8'h00;
    localparam logic [2:0] VT_HI_RST = 3'h0;
    localparam logic [7:0] IT_RST    = 8'h00;

endpackage : srec_pkg

// ===== design/srec_servo_if.sv
`timescale 1ns/1ps
interface srec_servo_if #(parameter int W = 11);
    logic [W-1:0] target;
    logic         tick;
    logic         hold;
    logic [W-1:0] code;
    logic         at_target;

    modport ctl  (output target, output tick, output hold, input code, input at_target);
    modport chan (input target, input tick, input hold, output code, output at_target);
endinterface : srec_servo_if

// ===== design/srec_servo_chan.sv
`timescale 1ns/1ps
module srec_servo_chan
    import srec_pkg::*;
#(
    parameter int W = VCODE_W
)
(
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    srec_servo_if.chan  sv
);

    typedef struct packed {
        logic [W-1:0] code;
    } srec_chan_st_t;

    srec_chan_st_t st_q;
    srec_chan_st_t st_d;

    if (W < 1 || W > 16)
    begin : g_bad_width
        $error("srec_servo_chan: width out of range");
    end

    // One count per tick toward the target, zero while held
    always_comb
    begin
        st_d = st_q;
        if (sv.hold)
        begin
            st_d.code = '0;
        end
        else if (sv.tick && (st_q.code < sv.target))
        begin
            st_d.code = st_q.code + {{(W-1){1'b0}}, 1'b1};
        end
        else if (sv.tick && (st_q.code > sv.target))
        begin
            st_d.code = st_q.code - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sv.code      = st_q.code;
    assign sv.at_target = (st_q.code == sv.target);

    a_still_without_tick: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!sv.hold && !sv.tick) |=> $stable(st_q.code))
        else $error("servo code moved without a tick");

    a_step_up_one: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!sv.hold && sv.tick && (st_q.code < sv.target)) |=> (st_q.code == $past(st_q.code) + 1'b1))
        else $error("servo code did not step up by one");

    a_step_down_one: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!sv.hold && sv.tick && (st_q.code > sv.target)) |=> (st_q.code == $past(st_q.code) - 1'b1))
        else $error("servo code did not step down by one");

    a_hold_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        sv.hold |=> (st_q.code == '0))
        else $error("held servo code not zero");

    c_reach_target: cover property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!sv.at_target && !sv.hold) ##1 sv.at_target);

endmodule : srec_servo_chan

// ===== design/srec_top.sv
`timescale 1ns/1ps
// What this block does
// - Active voltage target changes only on a load command, as one 11-bit word.
// - Current reference code comes from the 8-bit current target register.
// - Each servo counter steps one count per divided tick toward its target.
// - Voltage and current servo channels run independently and at the same time.
// - Voltage servo counter doubles as the soft-start ramp after enable.
// - Two-bit field picks the servo clock division ratio for both channels.
// - Internal enable low keeps the regulator disabled, no switching.
// - Internal enable high enables the regulator toward the servo reference.
// - Discharge select high turns the discharge resistor on while disabled.
// - Discharge select low leaves the output floating while disabled.
// - Open enable pin reads high, so regulator enables once bias is ready.
// - Internal enable is bias ready AND the OR of enable pin and software enable bit.
// - Voltage servo counter held at zero while internal enable is low.
// - Voltage targets above 0x780 are accepted but clamped to 0x780.
module srec_top
    import srec_pkg::*;
#(
    parameter int DIV_W = DIV_CNT_W
)
(
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RST_N,
    input  wire logic [ADDR_W-1:0]   I_ADDR,
    input  wire logic [DATA_W-1:0]   I_WDATA,
    input  wire logic                I_WR,
    input  wire logic                I_RD,
    input  wire logic                I_EN_PIN,
    input  wire logic                I_BIAS_READY,
    output wire logic [DATA_W-1:0]   O_RDATA,
    output wire logic [VCODE_W-1:0]  O_VREF_CODE,
    output wire logic [ICODE_W-1:0]  O_IREF_CODE,
    output wire logic                O_REG_ENABLE,
    output wire logic                O_DISCHARGE_ON,
    output wire logic                O_SERVO_BUSY
);

    typedef struct packed {
        logic               en_s1;
        logic               en_s2;
        logic               bias_s1;
        logic               bias_s2;
        logic               sw_en;
        logic               load;
        logic [1:0]         div_sel;
        logic               dis_sel;
        logic [7:0]         vt_lo;
        logic [VT_HI_W-1:0] vt_hi;
        logic [ICODE_W-1:0] it;
        logic [VCODE_W-1:0] vtarget;
        logic [DIV_W-1:0]   div_cnt;
        logic               tick;
        logic               internal_enable;
        logic               reg_en;
        logic               dis_on;
        logic               busy;
        logic [DATA_W-1:0]  rdata;
    } srec_top_st_t;

    localparam srec_top_st_t ST_RST = '{
        en_s1:   1'b0,
        en_s2:   1'b0,
        bias_s1: 1'b0,
        bias_s2: 1'b0,
        sw_en:   SWEN_RST,
        load:    1'b0,
        div_sel: DIV_RST,
        dis_sel: DIS_RST,
        vt_lo:   VT_LO_RST,
        vt_hi:   VT_HI_RST,
        it:      IT_RST,
        vtarget: '0,
        div_cnt: '0,
        tick:    1'b0,
        internal_enable:     1'b0,
        reg_en:  1'b0,
        dis_on:  1'b0,
        busy:    1'b0,
        rdata:   '0
    };

    if (DIV_W < 6 || DIV_W > 16)
    begin : g_bad_div
        $error("srec_top: divider width cannot hold the largest ratio");
    end

    srec_top_st_t st_q;
    srec_top_st_t st_d;
    logic         v_busy;
    logic         i_busy;
    logic         busy_now;

    srec_servo_if #(.W(VCODE_W)) v_if ();
    srec_servo_if #(.W(ICODE_W)) i_if ();

    function automatic logic [DIV_W-1:0] div_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = DIV_LIM0;
        case (sel)
            2'h0: lim = DIV_LIM0;
            2'h1: lim = DIV_LIM1;
            2'h2: lim = DIV_LIM2;
            2'h3: lim = DIV_LIM3;
        endcase
        return DIV_W'(lim);
    endfunction : div_limit

    function automatic logic [VCODE_W-1:0] clamp_code(input logic [VCODE_W-1:0] c);
        return (c > VCODE_MAX) ? VCODE_MAX : c;
    endfunction : clamp_code

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_a);
        return a == reg_a;
    endfunction : hit

    // Servo channel hookup
    assign v_if.target = st_q.vtarget;
    assign v_if.tick   = st_q.tick;
    assign v_if.hold   = !st_q.internal_enable;
    assign i_if.target = st_q.it;
    assign i_if.tick   = st_q.tick;
    assign i_if.hold   = 1'b0;

    assign v_busy   = st_q.internal_enable && !v_if.at_target;
    assign i_busy   = !i_if.at_target;
    assign busy_now = v_busy || i_busy;

    srec_servo_chan #(.W(VCODE_W)) u_vchan (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RST_N),
        .sv      (v_if.chan)
    );

    srec_servo_chan #(.W(ICODE_W)) u_ichan (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RST_N),
        .sv      (i_if.chan)
    );

    always_comb
    begin
        st_d = st_q;

        // Pin synchronisers
        st_d.en_s1   = I_EN_PIN;
        st_d.en_s2   = st_q.en_s1;
        st_d.bias_s1 = I_BIAS_READY;
        st_d.bias_s2 = st_q.bias_s1;

        // Register writes
        st_d.load = 1'b0;
        if (I_WR && hit(I_ADDR, ADDR_CTRL))
        begin
            st_d.sw_en = I_WDATA[CTRL_SWEN_BIT];
            st_d.load  = I_WDATA[CTRL_LOAD_BIT];
        end
        if (I_WR && hit(I_ADDR, ADDR_CFG))
        begin
            st_d.div_sel = I_WDATA[CFG_DIV_LSB +: 2];
            st_d.dis_sel = I_WDATA[CFG_DIS_BIT];
        end
        if (I_WR && hit(I_ADDR, ADDR_VT_LO))
        begin
            st_d.vt_lo = I_WDATA;
        end
        if (I_WR && hit(I_ADDR, ADDR_VT_HI))
        begin
            st_d.vt_hi = I_WDATA[VT_HI_W-1:0];
        end
        if (I_WR && hit(I_ADDR, ADDR_IT))
        begin
            st_d.it = I_WDATA;
        end

        // Atomic transfer of the staged voltage word
        if (st_q.load)
        begin
            st_d.vtarget = clamp_code({st_q.vt_hi, st_q.vt_lo});
        end

        // Enable path
        st_d.internal_enable    = st_q.bias_s2 && (st_q.en_s2 || st_q.sw_en);
        st_d.reg_en = st_q.internal_enable;
        st_d.dis_on = !st_q.internal_enable && st_q.dis_sel;
        st_d.busy   = busy_now;

        // Servo clock divider, idle while both channels settled
        if (!busy_now)
        begin
            st_d.div_cnt = '0;
            st_d.tick    = 1'b0;
        end
        else if (st_q.div_cnt >= div_limit(st_q.div_sel))
        begin
            st_d.div_cnt = '0;
            st_d.tick    = 1'b1;
        end
        else
        begin
            st_d.div_cnt = st_q.div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            st_d.tick    = 1'b0;
        end

        // Read data, valid in the cycle after the strobe only
        st_d.rdata = '0;
        if (I_RD)
        begin
            case (I_ADDR)
                ADDR_CTRL:
                begin
                    st_d.rdata[CTRL_SWEN_BIT] = st_q.sw_en;
                    st_d.rdata[CTRL_LOAD_BIT] = st_q.load;
                end
                ADDR_CFG:
                begin
                    st_d.rdata[CFG_DIV_LSB +: 2] = st_q.div_sel;
                    st_d.rdata[CFG_DIS_BIT]      = st_q.dis_sel;
                end
                ADDR_VT_LO:    st_d.rdata = st_q.vt_lo;
                ADDR_VT_HI:    st_d.rdata[VT_HI_W-1:0] = st_q.vt_hi;
                ADDR_IT:       st_d.rdata = st_q.it;
                ADDR_STATUS:
                begin
                    st_d.rdata[STAT_IEN_BIT]  = st_q.internal_enable;
                    st_d.rdata[STAT_VBSY_BIT] = v_busy;
                    st_d.rdata[STAT_IBSY_BIT] = i_busy;
                    st_d.rdata[STAT_PIN_BIT]  = st_q.en_s2;
                    st_d.rdata[STAT_BIAS_BIT] = st_q.bias_s2;
                end
                ADDR_VCODE_LO: st_d.rdata = v_if.code[7:0];
                ADDR_VCODE_HI: st_d.rdata[VCODE_W-9:0] = v_if.code[VCODE_W-1:8];
                ADDR_ICODE:    st_d.rdata = i_if.code;
                default:       st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N)
        begin
            st_q <= ST_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign O_RDATA        = st_q.rdata;
    assign O_VREF_CODE    = v_if.code;
    assign O_IREF_CODE    = i_if.code;
    assign O_REG_ENABLE   = st_q.reg_en;
    assign O_DISCHARGE_ON = st_q.dis_on;
    assign O_SERVO_BUSY   = st_q.busy;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking

    default disable iff (!I_RST_N);

    a_target_only_load: assert property (
        !st_q.load |=> $stable(st_q.vtarget))
        else $error("voltage target changed without a load");

    a_load_takes_word: assert property (
        st_q.load |=> (st_q.vtarget == clamp_code($past({st_q.vt_hi, st_q.vt_lo}))))
        else $error("load did not transfer the staged word");

    a_clamp_ceiling: assert property (
        st_q.vtarget <= VCODE_MAX)
        else $error("voltage target above ceiling");

    a_load_self_clear: assert property (
        (st_q.load && !(I_WR && (I_ADDR == ADDR_CTRL))) |=> !st_q.load)
        else $error("load bit did not clear");

    a_ien_from_sources: assert property (
        (st_q.bias_s2 && (st_q.en_s2 || st_q.sw_en)) |=> st_q.internal_enable ##1 st_q.reg_en)
        else $error("internal enable did not follow its sources");

    a_off_no_switch: assert property (
        !st_q.internal_enable |=> (!st_q.reg_en && (v_if.code == '0)))
        else $error("regulator active while internal enable low");

    a_discharge_on: assert property (
        (!st_q.internal_enable && st_q.dis_sel) |=> (st_q.dis_on && !st_q.reg_en))
        else $error("discharge not on while disabled");

    a_discharge_off: assert property (
        !st_q.dis_sel |=> !st_q.dis_on)
        else $error("discharge on while not selected");

    a_tick_at_limit: assert property (
        st_q.tick |-> ($past(st_q.div_cnt) >= div_limit($past(st_q.div_sel))))
        else $error("servo tick before divider limit");

    a_idle_no_tick: assert property (
        !busy_now |=> (!st_q.tick && (st_q.div_cnt == '0)))
        else $error("divider ran while channels settled");

    a_rdata_one_cycle: assert property (
        !I_RD |=> (st_q.rdata == '0))
        else $error("read data present without a read");

    a_ien_low_off: assert property (
        !(st_q.bias_s2 && (st_q.en_s2 || st_q.sw_en)) |=> !st_q.internal_enable)
        else $error("internal enable high with no source");

    a_reg_en_on: assert property (
        st_q.internal_enable |=> st_q.reg_en)
        else $error("regulator not enabled after internal enable");

    a_cur_target_direct: assert property (
        (I_WR && (I_ADDR == ADDR_IT)) |=> (st_q.it == $past(I_WDATA)))
        else $error("current target write not taken");

    a_div_count_up: assert property (
        (busy_now && (st_q.div_cnt < div_limit(st_q.div_sel))) |=> (st_q.div_cnt == $past(st_q.div_cnt) + 1'b1))
        else $error("servo divider did not count");

    a_busy_flag: assert property (
        (v_busy || i_busy) |=> st_q.busy)
        else $error("busy flag low while a channel moves");

    c_soft_start: cover property (
        (!st_q.internal_enable ##1 st_q.internal_enable) ##[1:40] (v_if.code != '0));

    c_both_ramp: cover property (
        st_q.tick && v_busy && i_busy);

    c_pin_only_enable: cover property (
        st_q.internal_enable && !st_q.sw_en);

    c_discharge: cover property (
        st_q.dis_on);

endmodule : srec_top

// ===== verification/srec_host_model.sv
`timescale 1ns/1ps
module srec_host_model
    import srec_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [DATA_W-1:0] i_rdata,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_wdata,
    output logic                   o_wr,
    output logic                   o_rd,
    output logic                   o_en_pin
);
    initial
    begin
        o_addr   = 8'h00;
        o_wdata  = 8'h00;
        o_wr     = 1'b0;
        o_rd     = 1'b0;
        o_en_pin = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd

    // Both target bytes first, load bit last
    task automatic load_vt(input logic [10:0] code, input logic swen);
        wr(ADDR_VT_LO, code[7:0]);
        wr(ADDR_VT_HI, {5'h00, code[10:8]});
        wr(ADDR_CTRL, {6'h00, 1'b1, swen});
    endtask : load_vt

    // Caller holds each level for several cycles
    task automatic pin(input logic v);
        @(posedge i_clk);
        o_en_pin <= v;
    endtask : pin
endmodule : srec_host_model

// ===== verification/srec_top_tb_top.sv
`timescale 1ns/1ps
module srec_top_tb_top
    import srec_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        bias;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd;
    logic        en_pin;
    logic [10:0] vref;
    logic [7:0]  iref;
    logic        reg_en;
    logic        dis_on;
    logic        busy;
    logic [7:0]  rv;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    srec_top u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .I_EN_PIN(en_pin), .I_BIAS_READY(bias), .O_RDATA(rdata), .O_VREF_CODE(vref),
        .O_IREF_CODE(iref), .O_REG_ENABLE(reg_en), .O_DISCHARGE_ON(dis_on), .O_SERVO_BUSY(busy));

    srec_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .o_en_pin(en_pin));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, rv);
        check(rv, exp);
    endtask : rd_chk

    task automatic wait_code(input bit cur, input logic [10:0] exp, input int max);
        int i;
        for (i = 0; i < max; i++)
        begin
            @(posedge clk);
            #1;
            if ((cur ? {3'h0, iref} : vref) === exp)
                break;
        end
        check(cur ? {3'h0, iref} : vref, exp);
    endtask : wait_code

    task automatic t_reset();
        rd_chk(ADDR_CTRL, {7'h00, SWEN_RST});
        rd_chk(ADDR_CFG, {DIV_RST, 1'b0, DIS_RST, 4'h0});
        rd_chk(ADDR_VT_LO, VT_LO_RST);
        rd_chk(ADDR_VT_HI, {5'h00, VT_HI_RST});
        rd_chk(ADDR_IT, IT_RST);
        rd_chk(8'h20, 8'h00);
        check(vref, 16'h0000);
        check(iref, 16'h0000);
    endtask : t_reset

    task automatic t_disable();
        u_host.wr(ADDR_CFG, 8'h10);
        repeat (4) @(posedge clk);
        check(dis_on, 1'b1);
        check(reg_en, 1'b0);
        u_host.wr(ADDR_CFG, 8'h00);
        repeat (4) @(posedge clk);
        check(dis_on, 1'b0);
        u_host.load_vt(11'h020, 1'b0);
        repeat (10) @(posedge clk);
        check(vref, 16'h0000);
    endtask : t_disable

    task automatic t_enable();
        u_host.pin(1'b1);
        repeat (6) @(posedge clk);
        check(reg_en, 1'b1);
        check(vref < 11'h00a, 1'b1);
        wait_code(0, 11'h020, 200);
        @(posedge clk);
        bias <= 1'b0;
        repeat (6) @(posedge clk);
        check(reg_en, 1'b0);
        check(vref, 16'h0000);
        bias <= 1'b1;
        repeat (6) @(posedge clk);
        check(reg_en, 1'b1);
        wait_code(0, 11'h020, 200);
        u_host.pin(1'b0);
        repeat (6) @(posedge clk);
        check(reg_en, 1'b0);
        u_host.wr(ADDR_CFG, 8'h10);
        repeat (4) @(posedge clk);
        check(dis_on, 1'b1);
        u_host.wr(ADDR_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        check(reg_en, 1'b1);
        check(dis_on, 1'b0);
    endtask : t_enable

    task automatic t_load();
        wait_code(0, 11'h020, 200);
        u_host.wr(ADDR_VT_LO, 8'h40);
        repeat (20) @(posedge clk);
        check(vref, 16'h0020);
        u_host.wr(ADDR_VT_HI, 8'h01);
        repeat (20) @(posedge clk);
        check(vref, 16'h0020);
        u_host.wr(ADDR_CTRL, 8'h03);
        rd_chk(ADDR_CTRL, 8'h01);
        wait_code(0, 11'h140, 400);
        u_host.load_vt(11'h13c, 1'b1);
        wait_code(0, 11'h13c, 40);
    endtask : t_load

    task automatic t_clamp();
        u_host.load_vt(11'h7ff, 1'b1);
        rd_chk(ADDR_VT_HI, 8'h07);
        wait_code(0, VCODE_MAX, 2500);
        repeat (5) @(posedge clk);
        check(vref, VCODE_MAX);
        check(busy, 1'b0);
        rd_chk(ADDR_STATUS, 8'h11);
        rd_chk(ADDR_VCODE_LO, 8'h80);
        rd_chk(ADDR_VCODE_HI, 8'h07);
    endtask : t_clamp

    task automatic t_div();
        int sel;
        int n;
        logic [7:0] cur;
        logic [7:0] prev;
        for (sel = 0; sel < 4; sel++)
        begin
            u_host.wr(ADDR_CFG, {sel[1:0], 6'h00});
            cur = iref;
            u_host.wr(ADDR_IT, cur + 8'h03);
            for (n = 0; n < 200 && iref === cur; n++)
            begin
                @(posedge clk);
                #1;
            end
            prev = iref;
            for (n = 0; n < 200 && iref === prev; n++)
            begin
                @(posedge clk);
                #1;
            end
            check(n[15:0], 16'h0001 << (2 * sel));
            wait_code(1, {3'h0, cur + 8'h03}, 300);
        end
    endtask : t_div

    task automatic t_parallel();
        logic [7:0] i0;
        u_host.wr(ADDR_CFG, 8'h40);
        u_host.load_vt(11'h700, 1'b1);
        i0 = iref;
        u_host.wr(ADDR_IT, i0 + 8'h14);
        repeat (40) @(posedge clk);
        check((vref < VCODE_MAX) && (iref > i0), 1'b1);
        wait_code(1, {3'h0, i0 + 8'h14}, 200);
        rd_chk(ADDR_ICODE, i0 + 8'h14);
        wait_code(0, 11'h700, 600);
    endtask : t_parallel

    task automatic t_rerst();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(vref, 16'h0000);
        check(iref, 16'h0000);
        check(reg_en, 1'b0);
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CFG, 8'h00);
        rd_chk(ADDR_IT, 8'h00);
    endtask : t_rerst

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run needs under 8000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        bias  = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_disable();
        t_enable();
        t_load();
        t_clamp();
        t_div();
        t_parallel();
        t_rerst();
        final_report();
    end
endmodule : srec_top_tb_top
